// ---- hdl/core_pc_stack_indirect_irq.sv ----
// program counter, return stack, indirect access and interrupt control
`timescale 1ns/1ps
module core_pc_stack_indirect_irq #(
   parameter int STACK_DEPTH = core_seq_pkg::STACK_DEPTH
)(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [core_seq_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [core_seq_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [core_seq_pkg::DATA_W-1:0] reg_rdata_q,
   output logic reg_rd_own_q,
   input wire core_seq_pkg::seq_req_t seq_req,
   input wire logic indirect_bank_bit,
   input wire core_seq_pkg::irq_events_t irq_events,
   input wire core_seq_pkg::reset_source_t reset_source,
   input wire logic brownout_detect_enable,
   output logic [core_seq_pkg::PC_W-1:0] pc_q,
   output core_seq_pkg::mem_req_t mem_req_q,
   output logic irq_request_q
);
   import core_seq_pkg::*;

   localparam int SP_W = $clog2(STACK_DEPTH);

   // ------------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------------
   // banked registers match the full address, the rest are mirrored
   function automatic reg_sel_t reg_decode(input logic [7:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      if ((a & MIRROR_MASK) == ADDR_INDIRECT_PORT)
         s = SEL_INDIRECT;
      else if ((a & MIRROR_MASK) == ADDR_PC_LOW)
         s = SEL_PC_LOW;
      else if ((a & MIRROR_MASK) == ADDR_POINTER)
         s = SEL_POINTER;
      else if ((a & MIRROR_MASK) == ADDR_PC_HIGH_LATCH)
         s = SEL_HIGH_LATCH;
      else if ((a & MIRROR_MASK) == ADDR_INTERRUPT_CONTROL)
         s = SEL_INT_CONTROL;
      else if (a == ADDR_COMPARATOR_FLAGS)
         s = SEL_CMP_FLAGS;
      else if (a == ADDR_COMPARATOR_ENABLES)
         s = SEL_CMP_ENABLES;
      else if (a == ADDR_RESET_CAUSE)
         s = SEL_RESET_CAUSE;
      return s;
   endfunction

   logic [7:0] pointer_q;
   logic [LATCH_W-1:0] high_latch_q;
   logic [7:0] int_control_q;
   logic [7:0] int_control_d;
   logic [7:0] cmp_flags_q;
   logic [7:0] cmp_flags_d;
   logic [7:0] cmp_enables_q;
   logic [7:0] reset_cause_q;
   logic rst_seen_q;
   logic [PC_W-1:0] pc_d;
   logic [PC_W-1:0] stack_mem [STACK_DEPTH];
   logic [SP_W-1:0] sp_q;
   logic [PC_W-1:0] stack_top;
   logic [PC_W-1:0] push_val;
   logic push;
   logic pop;
   reg_sel_t raw_sel;
   reg_sel_t eff_sel;
   logic indirect;
   logic self_indirect;
   logic [8:0] eff_addr;
   logic wr_en;
   logic pc_low_wr;
   logic core_pending;
   logic periph_pending;

   // ------------------------------------------------------------------
   // indirect resolution
   // ------------------------------------------------------------------
   // the port's own address is swapped for the pointer's target
   assign raw_sel = reg_decode(reg_addr);
   assign indirect = (raw_sel == SEL_INDIRECT); // [RQ18]
   assign eff_addr = indirect ?
      {indirect_bank_bit & BANK_BIT_USED, pointer_q} : // [RQ21] [RQ22]
      {1'b0, reg_addr};
   assign eff_sel = reg_decode(eff_addr[7:0]);
   assign self_indirect = indirect && (eff_sel == SEL_INDIRECT);
   assign wr_en = reg_wr && !self_indirect; // [RQ20]
   assign pc_low_wr = wr_en && (eff_sel == SEL_PC_LOW);

   // ------------------------------------------------------------------
   // return stack
   // ------------------------------------------------------------------
   // pointer is internal only and wraps, so old entries are overwritten
   assign push = (seq_req.op == SEQ_CALL) || (seq_req.op == SEQ_VECTOR);
   assign pop = (seq_req.op == SEQ_RETURN) || (seq_req.op == SEQ_RETURN_FROM_INTERRUPT);
   assign stack_top = stack_mem[sp_q - SP_W'(1)];
   assign push_val = (seq_req.op == SEQ_CALL) ? pc_q + PC_ONE : pc_q;

   // stack storage, no reset on the array
   always_ff @(posedge clk)
   begin
      if (push)
         stack_mem[sp_q] <= push_val; // [RQ12] [RQ14]
   end

   // stack pointer, hidden from software
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         sp_q <= '0;
      else if (push)
         sp_q <= sp_q + SP_W'(1); // [RQ13] [RQ17]
      else if (pop)
         sp_q <= sp_q - SP_W'(1); // [RQ15] [RQ17]
   end

   // ------------------------------------------------------------------
   // program counter
   // ------------------------------------------------------------------
   // next counter value; a low-byte write beats any sequencing op
   always_comb
   begin
      pc_d = pc_q;
      case (seq_req.op)
         SEQ_HOLD: pc_d = pc_q;
         SEQ_STEP: pc_d = pc_q + PC_ONE;
         SEQ_GOTO, SEQ_CALL:
            pc_d = {high_latch_q[4:3], seq_req.target}; // [RQ9] [RQ10]
         SEQ_RETURN, SEQ_RETURN_FROM_INTERRUPT: pc_d = stack_top; // [RQ15]
         SEQ_VECTOR: pc_d = VECTOR_ADDR; // [RQ14]
         SEQ_ADD_LOW:
            pc_d = {pc_q[12:8], pc_q[7:0] + seq_req.target[7:0]}; // [RQ11]
         default: pc_d = pc_q;
      endcase
      if (pc_low_wr)
         pc_d = {high_latch_q, reg_wdata}; // [RQ6] [RQ8]
   end

   // counter register, cleared by reset
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pc_q <= PC_RST; // [RQ7]
      else
         pc_q <= pc_d; // [RQ5]
   end

   // ------------------------------------------------------------------
   // plain software registers
   // ------------------------------------------------------------------
   // high latch, written only by software
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         high_latch_q <= LATCH_RST;
      else if (wr_en && eff_sel == SEL_HIGH_LATCH)
         high_latch_q <= reg_wdata[LATCH_W-1:0]; // [RQ16]
   end

   // indirect pointer
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         pointer_q <= BYTE_ZERO;
      else if (wr_en && eff_sel == SEL_POINTER)
         pointer_q <= reg_wdata;
   end

   // comparator enables
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         cmp_enables_q <= BYTE_ZERO;
      else if (wr_en && eff_sel == SEL_CMP_ENABLES)
         cmp_enables_q <= reg_wdata;
   end

   // ------------------------------------------------------------------
   // interrupt control
   // ------------------------------------------------------------------
   // events set flags last so a same-cycle software clear loses
   always_comb
   begin
      int_control_d = int_control_q;
      if (wr_en && eff_sel == SEL_INT_CONTROL)
         int_control_d = reg_wdata;
      if (seq_req.op == SEQ_VECTOR)
         int_control_d[GIE_BIT] = 1'b0;
      else if (seq_req.op == SEQ_RETURN_FROM_INTERRUPT)
         int_control_d[GIE_BIT] = 1'b1;
      if (irq_events.timer_overflow)
         int_control_d[TIMER_OVERFLOW_FLAG_BIT] = 1'b1; // [RQ1]
      if (irq_events.external_pin)
         int_control_d[EXTERNAL_PIN_FLAG_BIT] = 1'b1; // [RQ1]
      if (irq_events.port_change)
         int_control_d[PORT_CHANGE_FLAG_BIT] = 1'b1; // [RQ1]
   end

   // comparator flag, same set-wins ordering
   always_comb
   begin
      cmp_flags_d = cmp_flags_q;
      if (wr_en && eff_sel == SEL_CMP_FLAGS)
         cmp_flags_d = reg_wdata;
      if (irq_events.comparator)
         cmp_flags_d[CMP_IRQ_BIT] = 1'b1; // [RQ1]
   end

   // flag and enable registers
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         int_control_q <= BYTE_ZERO;
         cmp_flags_q <= BYTE_ZERO;
      end
      else
      begin
         int_control_q <= int_control_d;
         cmp_flags_q <= cmp_flags_d;
      end
   end

   // request needs flag, enable and global enable
   assign core_pending =
      (int_control_q[TIMER_OVERFLOW_IRQ_ENABLE_BIT] && int_control_q[TIMER_OVERFLOW_FLAG_BIT]) ||
      (int_control_q[INTE_BIT] && int_control_q[EXTERNAL_PIN_FLAG_BIT]) ||
      (int_control_q[PORT_CHANGE_IRQ_ENABLE_BIT] && int_control_q[PORT_CHANGE_FLAG_BIT]);
   assign periph_pending = int_control_q[PERIPHERAL_IRQ_ENABLE_BIT] &&
      cmp_enables_q[CMP_IRQ_BIT] && cmp_flags_q[CMP_IRQ_BIT];

   // registered interrupt request
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         irq_request_q <= 1'b0;
      else
         irq_request_q <= int_control_q[GIE_BIT] &&
            (core_pending || periph_pending); // [RQ23]
   end

   // ------------------------------------------------------------------
   // reset cause
   // ------------------------------------------------------------------
   // marks the first edge after release, when the cause is caught
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         rst_seen_q <= 1'b0;
      else
         rst_seen_q <= 1'b1;
   end

   // survives reset on purpose; bits power up unknown
   always_ff @(posedge clk)
   begin
      if (!rst_seen_q)
      begin
         if (reset_source.power_on)
            reset_cause_q[RC_POR_N_BIT] <= 1'b0; // [RQ2] [RQ3]
         if (reset_source.master_clear)
            reset_cause_q[RC_EXTERNAL_MASTER_CLEAR_N_BIT] <= 1'b0; // [RQ2]
         if (reset_source.watchdog)
            reset_cause_q[RC_WDT_N_BIT] <= 1'b0; // [RQ2]
         if (reset_source.brownout && brownout_detect_enable)
            reset_cause_q[RC_BOR_N_BIT] <= 1'b0; // [RQ2] [RQ4]
         reset_cause_q[RC_BROWNOUT_DETECT_ENABLE_BIT] <= brownout_detect_enable;
         reset_cause_q[7:5] <= 3'h0;
      end
      else if (wr_en && eff_sel == SEL_RESET_CAUSE)
         reset_cause_q[3:0] <= (reset_cause_q[3:0] & ~RC_SW_MASK[3:0]) |
            (reg_wdata[3:0] & RC_SW_MASK[3:0]); // [RQ3]
   end

   // ------------------------------------------------------------------
   // read port and memory forwarding
   // ------------------------------------------------------------------
   // read data stand only in the cycle after the strobe
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         reg_rdata_q <= BYTE_ZERO;
         reg_rd_own_q <= 1'b0;
      end
      else
      begin
         reg_rdata_q <= BYTE_ZERO;
         reg_rd_own_q <= reg_rd && (eff_sel != SEL_NONE);
         if (reg_rd)
            case (eff_sel)
               SEL_INDIRECT: reg_rdata_q <= READ_SELF; // [RQ19]
               SEL_PC_LOW: reg_rdata_q <= pc_q[7:0]; // [RQ5]
               SEL_POINTER: reg_rdata_q <= pointer_q;
               SEL_HIGH_LATCH: reg_rdata_q <= {3'h0, high_latch_q};
               SEL_INT_CONTROL: reg_rdata_q <= int_control_q;
               SEL_CMP_FLAGS: reg_rdata_q <= cmp_flags_q;
               SEL_CMP_ENABLES: reg_rdata_q <= cmp_enables_q;
               SEL_RESET_CAUSE: reg_rdata_q <= reset_cause_q;
               default: reg_rdata_q <= BYTE_ZERO;
            endcase
      end
   end

   // accesses to locations outside this block go to data memory
   always_ff @(posedge clk or posedge sys_rst)
   begin
      if (sys_rst)
         mem_req_q <= '0;
      else
      begin
         mem_req_q.addr <= eff_addr; // [RQ18]
         mem_req_q.wdata <= reg_wdata;
         mem_req_q.wr <= reg_wr && (eff_sel == SEL_NONE);
         mem_req_q.rd <= reg_rd && (eff_sel == SEL_NONE);
      end
   end

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_call;
      seq_req.op == SEQ_CALL && !pc_low_wr;
   endsequence
   sequence s_return;
      seq_req.op == SEQ_RETURN && !pc_low_wr;
   endsequence

   property p_flag_set;
      irq_events.timer_overflow |=> int_control_q[TIMER_OVERFLOW_FLAG_BIT];
   endproperty
   a_flag_set: assert property (p_flag_set) // [RQ1]
      else $error("timer flag not set by event");

   property p_low_write;
      pc_low_wr |=> pc_q == {$past(high_latch_q), $past(reg_wdata)};
   endproperty
   a_low_write: assert property (p_low_write) // [RQ8]
      else $error("low byte write did not load counter");

   property p_goto;
      seq_req.op == SEQ_GOTO && !pc_low_wr |=>
         pc_q == {$past(high_latch_q[4:3]), $past(seq_req.target)};
   endproperty
   a_goto: assert property (p_goto) // [RQ9]
      else $error("goto target wrong");

   property p_add_low;
      seq_req.op == SEQ_ADD_LOW && !pc_low_wr |=>
         pc_q[12:8] == $past(pc_q[12:8]);
   endproperty
   a_add_low: assert property (p_add_low) // [RQ11]
      else $error("low byte add carried upward");

   property p_call_return;
      s_call ##1 s_return |=> pc_q == $past(pc_q, 2) + PC_ONE;
   endproperty
   a_call_return: assert property (p_call_return) // [RQ15]
      else $error("return address wrong");

   property p_latch_kept;
      (push || pop) && !reg_wr |=> $stable(high_latch_q);
   endproperty
   a_latch_kept: assert property (p_latch_kept) // [RQ16]
      else $error("high latch moved on push or pop");

   property p_self_read;
      reg_rd && self_indirect |=> reg_rdata_q == READ_SELF && reg_rd_own_q;
   endproperty
   a_self_read: assert property (p_self_read) // [RQ19]
      else $error("self indirect read not zero");

   property p_self_write;
      reg_wr && self_indirect |=> !mem_req_q.wr && $stable(pointer_q);
   endproperty
   a_self_write: assert property (p_self_write) // [RQ20]
      else $error("self indirect write stored data");

   property p_no_global;
      !int_control_q[GIE_BIT] |=> !irq_request_q;
   endproperty
   a_no_global: assert property (p_no_global) // [RQ23]
      else $error("request without global enable");

   property p_indirect_fwd;
      reg_rd && indirect && eff_sel == SEL_NONE |=>
         mem_req_q.rd && mem_req_q.addr == {1'b0, $past(pointer_q)};
   endproperty
   a_indirect_fwd: assert property (p_indirect_fwd) // [RQ22]
      else $error("indirect read not forwarded to pointer");

endmodule

// ---- hdl/core_seq_pkg.sv ----
// constants and types for the core sequencing block
//
// Contract
// RQ1: interrupt flags set on their event whatever the enable bits hold.
// RQ2: reset-cause register tells power-on, master-clear, watchdog, brown-out apart.
// RQ3: brown-out flag unknown after power-on; software sets it, brown-out clears.
// RQ4: brown-out flag is unspecified while brown-out detection is disabled.
// RQ5: program counter is 13 bits; its low byte is a read/write register.
// RQ6: upper counter bits not directly accessible; loaded only from high latch.
// RQ7: every reset clears the whole program counter.
// RQ8: a low-byte write copies high-latch bits 4..0 into upper counter bits.
// RQ9: call and goto take the top two counter bits from latch bits 4..3.
// RQ10: call and goto take the lower eleven bits from the instruction.
// RQ11: adding to the low byte never carries into upper bits.
// RQ12: eight-entry, 13-bit return stack outside program and data space.
// RQ13: stack pointer is not reachable by software.
// RQ14: counter pushed on call and on interrupt vectoring.
// RQ15: return, return-with-literal and return-from-interrupt pop into the counter.
// RQ16: pushes and pops leave the high latch unchanged.
// RQ17: stack is circular, ninth push overwrites first; no overflow status.
// RQ18: accesses to the indirect port go to the location the pointer selects.
// RQ19: reading the indirect port through itself returns 00h.
// RQ20: writing the indirect port through itself stores nothing.
// RQ21: effective indirect address is bank bit above the 8-bit pointer.
// RQ22: the indirect bank bit has no effect on addressing here.
// RQ23: interrupt needs flag, enable, global enable; peripherals also peripheral enable.
package core_seq_pkg;

   // ------------------------------------------------------------------
   // widths
   // ------------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int PC_W = 13;
   localparam int LIT_W = 11;
   localparam int LATCH_W = 5;
   localparam int STACK_DEPTH = 8;
   localparam logic BANK_BIT_USED = 1'b0;

   // ------------------------------------------------------------------
   // register map
   // ------------------------------------------------------------------
   localparam logic [7:0] ADDR_INDIRECT_PORT = 8'h00;
   localparam logic [7:0] ADDR_PC_LOW = 8'h02;
   localparam logic [7:0] ADDR_POINTER = 8'h04;
   localparam logic [7:0] ADDR_PC_HIGH_LATCH = 8'h0A;
   localparam logic [7:0] ADDR_INTERRUPT_CONTROL = 8'h0B;
   localparam logic [7:0] ADDR_COMPARATOR_FLAGS = 8'h0C;
   localparam logic [7:0] ADDR_COMPARATOR_ENABLES = 8'h8C;
   localparam logic [7:0] ADDR_RESET_CAUSE = 8'h8E;
   localparam logic [7:0] MIRROR_MASK = 8'h7F;

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int GIE_BIT = 7;
   localparam int PERIPHERAL_IRQ_ENABLE_BIT = 6;
   localparam int TIMER_OVERFLOW_IRQ_ENABLE_BIT = 5;
   localparam int INTE_BIT = 4;
   localparam int PORT_CHANGE_IRQ_ENABLE_BIT = 3;
   localparam int TIMER_OVERFLOW_FLAG_BIT = 2;
   localparam int EXTERNAL_PIN_FLAG_BIT = 1;
   localparam int PORT_CHANGE_FLAG_BIT = 0;
   localparam int CMP_IRQ_BIT = 6;
   localparam int RC_BOR_N_BIT = 0;
   localparam int RC_POR_N_BIT = 1;
   localparam int RC_WDT_N_BIT = 2;
   localparam int RC_EXTERNAL_MASTER_CLEAR_N_BIT = 3;
   localparam int RC_BROWNOUT_DETECT_ENABLE_BIT = 4;
   localparam logic [7:0] RC_SW_MASK = 8'h0F;

   // ------------------------------------------------------------------
   // reset values and fixed numbers
   // ------------------------------------------------------------------
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] READ_SELF = 8'h00;
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic [12:0] PC_ONE = 13'h0001;
   localparam logic [12:0] VECTOR_ADDR = 13'h0004;
   localparam logic [4:0] LATCH_RST = 5'h00;

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [2:0] {
      SEQ_HOLD = 3'b000,
      SEQ_STEP = 3'b001,
      SEQ_GOTO = 3'b010,
      SEQ_CALL = 3'b011,
      SEQ_RETURN = 3'b100,
      SEQ_RETURN_FROM_INTERRUPT = 3'b101,
      SEQ_VECTOR = 3'b110,
      SEQ_ADD_LOW = 3'b111
   } seq_op_t;

   typedef enum logic [3:0] {
      SEL_NONE = 4'b0000,
      SEL_INDIRECT = 4'b0001,
      SEL_PC_LOW = 4'b0010,
      SEL_POINTER = 4'b0011,
      SEL_HIGH_LATCH = 4'b0100,
      SEL_INT_CONTROL = 4'b0101,
      SEL_CMP_FLAGS = 4'b0110,
      SEL_CMP_ENABLES = 4'b0111,
      SEL_RESET_CAUSE = 4'b1000
   } reg_sel_t;

   typedef struct packed {
      seq_op_t op;
      logic [10:0] target;
   } seq_req_t;

   typedef struct packed {
      logic timer_overflow;
      logic external_pin;
      logic port_change;
      logic comparator;
   } irq_events_t;

   typedef struct packed {
      logic power_on;
      logic master_clear;
      logic watchdog;
      logic brownout;
   } reset_source_t;

   typedef struct packed {
      logic [8:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } mem_req_t;

endpackage

// ---- tb/testbench.sv ----
// self-checking bench for the core sequencing block
`timescale 1ns/1ps
module testbench;
   import core_seq_pkg::*;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic clk, sys_rst, reg_wr, reg_rd, indirect_bank_bit, reg_rd_own_q;
   logic brownout_detect_enable, irq_request_q, own;
   logic [7:0] reg_addr, reg_wdata, reg_rdata_q, rdat;
   logic [12:0] pc_q;
   seq_req_t seq_req;
   irq_events_t irq_events;
   reset_source_t reset_source;
   mem_req_t mem_req_q, mreq;
   int fails, total_checks;
   logic [23:0] rows [7] = '{24'h04A5A5, 24'h845A5A, 24'h0AFF1F,
      24'h8A0C0C, 24'h8C4040, 24'h0B3838, 24'h0B0000};

   core_pc_stack_indirect_irq dut_u (.clk(clk), .sys_rst(sys_rst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
      .reg_rd_own_q(reg_rd_own_q), .seq_req(seq_req),
      .indirect_bank_bit(indirect_bank_bit), .irq_events(irq_events),
      .reset_source(reset_source),
      .brownout_detect_enable(brownout_detect_enable), .pc_q(pc_q),
      .mem_req_q(mem_req_q), .irq_request_q(irq_request_q));

   // ---------------------------------------------------------------
   // clock and watchdog
   // ---------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   initial
   begin
      #500000;
      fails++;
      report_and_stop();
   end

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e)
      begin
         fails++;
         $display("CHECK FAILED %s exp %0h got %0h", n, e, g);
      end
   endtask
   // one-cycle write strobe, then look at the memory request
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
      #1 mreq = mem_req_q;
   endtask
   // read data sits in the cycle after the strobe only
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      rdat = reg_rdata_q;
      own = reg_rd_own_q;
      mreq = mem_req_q;
   endtask
   task automatic op(input seq_op_t o, input logic [10:0] t);
      @(posedge clk);
      seq_req <= {o, t};
      @(posedge clk);
      seq_req <= {SEQ_HOLD, 11'h000};
      #1;
   endtask
   task automatic ev(input irq_events_t e);
      @(posedge clk);
      irq_events <= e;
      @(posedge clk);
      irq_events <= 4'h0;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic rst(input reset_source_t s);
      sys_rst <= 1'b1;
      reset_source <= s;
      repeat (16) @(posedge clk);
      sys_rst <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      {reg_wr, reg_rd, indirect_bank_bit, fails, total_checks} = '0;
      {reg_addr, reg_wdata} = '0;
      seq_req = {SEQ_HOLD, 11'h000};
      irq_events = 4'h0;
      brownout_detect_enable = 1'b1;
      sys_rst = 1'b1;
      rst(4'b1000);
      chk("pc after reset", 13'h0000, pc_q);
      rd(8'h8E);
      chk("cause power-on", 8'h10, rdat & 8'h12);
      // table of write-then-read cases
      foreach (rows[i])
      begin
         wr(rows[i][23:16], rows[i][15:8]);
         rd(rows[i][23:16]);
         chk("register readback", rows[i][7:0], rdat);
      end
      // low-byte write, computed add, call and return
      wr(8'h0A, 8'h15);
      wr(8'h02, 8'hF0);
      chk("pc low write", 13'h15F0, pc_q);
      op(SEQ_ADD_LOW, 11'h020);
      chk("add no carry", 13'h1510, pc_q);
      rd(8'h02);
      chk("pc low read", 8'h10, rdat);
      wr(8'h0A, 8'h18);
      op(SEQ_CALL, 11'h123);
      chk("call target", 13'h1923, pc_q);
      op(SEQ_RETURN, 11'h000);
      chk("return", 13'h1511, pc_q);
      rd(8'h0A);
      chk("latch kept", 8'h18, rdat);
      // read data and ownership stand one cycle only
      @(posedge clk);
      #1 chk("read data drops", 9'h000,
         {reg_rdata_q, reg_rd_own_q});
      // vector clears global enable, return-from-interrupt sets it
      wr(8'h0B, 8'h80);
      op(SEQ_VECTOR, 11'h000);
      chk("vector", 13'h0004, pc_q);
      rd(8'h0B);
      chk("gie cleared", 8'h00, rdat);
      op(SEQ_RETURN_FROM_INTERRUPT, 11'h000);
      chk("return_from_interrupt", 13'h1511, pc_q);
      rd(8'h0B);
      chk("gie set", 8'h80, rdat);
      // nine calls wrap the eight-entry stack
      wr(8'h0A, 8'h00);
      for (int i = 0; i < 9; i++)
         op(SEQ_CALL, 11'(i * 16 + 'h100));
      for (int j = 0; j < 9; j++)
      begin
         op(SEQ_RETURN, 11'h000);
         chk("stack pop", 13'((j < 8 ? 7 - j : 7) * 16 + 'h101),
            pc_q);
      end
      // flags latch whatever the enables hold
      wr(8'h0B, 8'h00);
      ev(4'b1000);
      rd(8'h0B);
      chk("timer flag", 8'h04, rdat);
      chk("no request", 1'b0, irq_request_q);
      ev(4'b0110);
      rd(8'h0B);
      chk("pin and port flags", 8'h07, rdat);
      wr(8'h0B, 8'hA4);
      repeat (2) @(posedge clk);
      #1 chk("timer request", 1'b1, irq_request_q);
      wr(8'h0B, 8'h24);
      repeat (2) @(posedge clk);
      #1 chk("gie off", 1'b0, irq_request_q);
      // event and software clear in one cycle: the event wins
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= 8'h0B;
      reg_wdata <= 8'h00;
      irq_events <= 4'b1000;
      @(posedge clk);
      reg_wr <= 1'b0;
      irq_events <= 4'h0;
      rd(8'h0B);
      chk("set beats clear", 8'h04, rdat);
      wr(8'h0B, 8'h80);
      ev(4'b0001);
      rd(8'h0C);
      chk("comparator flag", 8'h40, rdat);
      chk("peripheral_irq_enable off", 1'b0, irq_request_q);
      wr(8'h0B, 8'hC0);
      repeat (2) @(posedge clk);
      #1 chk("peripheral request", 1'b1, irq_request_q);
      wr(8'h0B, 8'h00);
      // indirect access, bank bit ignored
      indirect_bank_bit <= 1'b1;
      wr(8'h04, 8'h20);
      rd(8'h00);
      chk("ind read", {1'b0, 9'h020, 1'b1},
         {own, mreq.addr, mreq.rd});
      wr(8'h80, 8'h77);
      chk("ind write", {9'h020, 8'h77, 1'b1},
         {mreq.addr, mreq.wdata, mreq.wr});
      wr(8'h04, 8'h0A);
      wr(8'h0A, 8'h18);
      rd(8'h00);
      chk("ind own reg", 8'h18, rdat);
      wr(8'h04, 8'h00);
      rd(8'h00);
      chk("self read", {8'h00, 1'b1, 1'b0}, {rdat, own, mreq.rd});
      wr(8'h00, 8'h55);
      chk("self write", 1'b0, mreq.wr);
      // step, back-to-back call and return, goto
      op(SEQ_STEP, 11'h000);
      chk("step", 13'h0172, pc_q);
      @(posedge clk);
      seq_req <= {SEQ_CALL, 11'h0AB};
      @(posedge clk);
      seq_req <= {SEQ_RETURN, 11'h000};
      @(posedge clk);
      seq_req <= {SEQ_HOLD, 11'h000};
      #1 chk("call then return", 13'h0173, pc_q);
      op(SEQ_GOTO, 11'h7FF);
      chk("goto", 13'h1FFF, pc_q);
      // second reset, watchdog cause
      wr(8'h8E, 8'h0F);
      rd(8'h8E);
      chk("cause write", 8'h1F, rdat);
      rst(4'b0010);
      chk("pc second reset", 13'h0000, pc_q);
      rd(8'h8E);
      chk("cause watchdog", 8'h1B, rdat);
      // master-clear with detection off: brown-out not recorded
      wr(8'h8E, 8'h0F);
      brownout_detect_enable <= 1'b0;
      rst(4'b0101);
      rd(8'h8E);
      chk("cause master-clear", 8'h07, rdat);
      // brown-out with detection on clears its flag
      brownout_detect_enable <= 1'b1;
      rst(4'b0001);
      rd(8'h8E);
      chk("cause brown-out", 8'h16, rdat);
      report_and_stop();
   end
endmodule
